// ===== logic/rspd_map.vh
// Constants for the reset sync and power-save divider block.
// Assumes inclusion by bare name from the divider and top design files of the block.
`ifndef RSPD_MAP_VH
`define RSPD_MAP_VH

`define RSPD_ADDR_W 8
`define RSPD_DATA_W 16
`define RSPD_PSC_ADDR 8'h00
`define RSPD_STAT_ADDR 8'h04
`define RSPD_PSC_EN_BIT 15
`define RSPD_PSC_SEL_HI 1
`define RSPD_PSC_SEL_LO 0
`define RSPD_PSC_RESET 16'h0000
`define RSPD_PSC_WMASK 16'h8003
`define RSPD_STAT_ACT_EN 0
`define RSPD_STAT_SCLR_OUT 1
`define RSPD_STAT_PIN_RST 2
`define RSPD_STAT_BUS_ACT 3
`define RSPD_STAT_SEL_LO 4
`define RSPD_STAT_SEL_HI 5
`define RSPD_STAT_PEND 6
`define RSPD_STAT_EXIT 7
`define RSPD_WARM_MIN_PERIODS 4
`define RSPD_REL_FALLS 2'h2
`define RSPD_BUS_START_HALF 4'hD
`define RSPD_DIV_SEL_1 2'h0
`define RSPD_DIV_SEL_4 2'h1
`define RSPD_DIV_SEL_8 2'h2
`define RSPD_DIV_SEL_16 2'h3
`define RSPD_DIV_1 5'h01
`define RSPD_DIV_4 5'h04
`define RSPD_DIV_8 5'h08
`define RSPD_DIV_16 5'h10

`endif

// ===== logic/rspd_sync.v
// Two-stage synchroniser for pins entering the system clock domain.
// Assumes inputs are asynchronous levels; no pulse shorter than a cycle.
`timescale 1ns/1ps
module rspd_sync #(
	parameter WIDTH = 1
) (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire [WIDTH-1:0] d_i,
	output wire [WIDTH-1:0] q_o
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // rspd_sync

// ===== logic/rspd_divider.v
// Power-save divider: decides on which oscillator falls the clock toggles.
// Assumes osc_fall_i is a one-cycle pulse per falling oscillator edge.
`timescale 1ns/1ps
`include "rspd_map.vh"
module rspd_divider (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire osc_fall_i,
	input wire enable_i,
	input wire [1:0] sel_i,
	input wire restart_i,
	output wire toggle_o
);
	reg [4:0] count_q;
	reg [4:0] count_d;
	reg [4:0] period;

	always @* begin
		period = `RSPD_DIV_1;
		if (enable_i) begin
			case (sel_i)
				`RSPD_DIV_SEL_4: period = `RSPD_DIV_4;
				`RSPD_DIV_SEL_8: period = `RSPD_DIV_8;
				`RSPD_DIV_SEL_16: period = `RSPD_DIV_16;
				default: period = `RSPD_DIV_1;
			endcase
		end
	end

	// Toggle once every period oscillator falls on top of the halving
	assign toggle_o = osc_fall_i && (count_q >= period - 5'h01);

	always @* begin
		count_d = count_q;
		if (restart_i)
			count_d = 5'h00;
		else if (toggle_o)
			count_d = 5'h00;
		else if (osc_fall_i)
			count_d = count_q + 5'h01;
	end

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			count_q <= 5'h00;
		else
			count_q <= count_d;
	end
endmodule // rspd_divider

// ===== logic/rspd_top.v
// Reset synchroniser, processor clock generator and power-save divider.
// Assumes the core pulses third_bus_state_i at each third-state fall and
// that oscillator, clear and bus request arrive asynchronously on pins.
`timescale 1ns/1ps
`include "rspd_map.vh"
module rspd_top (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire oscillator_input_i,
	input wire system_clear_input_n_i,
	input wire bus_request_i,
	input wire third_bus_state_i,
	input wire unmasked_irq_i,
	input wire nmi_i,
	input wire [`RSPD_ADDR_W-1:0] reg_addr_i,
	input wire [`RSPD_DATA_W-1:0] reg_wdata_i,
	input wire reg_we_i,
	input wire reg_re_i,
	output wire [`RSPD_DATA_W-1:0] reg_rdata_o,
	output wire clkout_o,
	output wire system_clear_output_o,
	output wire pins_reset_o,
	output wire phase_realign_pulse_o,
	output wire bus_grant_ack_o,
	output wire bus_active_o,
	output wire prefetch_enable_o,
	output wire power_save_active_o
);
	wire [2:0] pin_raw;
	wire [2:0] pin_sync;
	wire osc_s;
	wire sclr_n_s;
	wire bus_req_s;
	wire osc_fall;
	wire div_toggle;
	wire toggle_eff;
	wire skip_beat;
	wire clock_fall;
	wire warm_enter;
	wire recognise;
	wire sclr_fall;
	wire psc_write;
	wire stat_hit;
	wire psc_hit;
	wire exit_req;
	wire apply;
	wire sw_pend;
	wire exit_set;
	wire exit_taken;
	wire rel_last;
	wire start_last;

	reg osc_prev_q;
	reg sclr_smp_q;
	reg sclr_smp_d;
	reg clkout_q;
	reg clkout_d;
	reg pins_reset_q;
	reg pins_reset_d;
	reg sclr_out_q;
	reg sclr_out_d;
	reg realign_q;
	reg realign_d;
	reg recog_q;
	reg recog_d;
	reg [1:0] rel_cnt_q;
	reg [1:0] rel_cnt_d;
	reg [3:0] start_cnt_q;
	reg [3:0] start_cnt_d;
	reg bus_active_q;
	reg bus_active_d;
	reg [`RSPD_DATA_W-1:0] psc_q;
	reg [`RSPD_DATA_W-1:0] psc_d;
	reg act_en_q;
	reg act_en_d;
	reg [1:0] act_sel_q;
	reg [1:0] act_sel_d;
	reg pend_q;
	reg pend_d;
	reg exit_pend_q;
	reg exit_pend_d;
	reg [`RSPD_DATA_W-1:0] rdata_q;
	reg [`RSPD_DATA_W-1:0] rdata_d;
	reg [`RSPD_DATA_W-1:0] stat_word;

	assign pin_raw = {bus_request_i, system_clear_input_n_i,
		oscillator_input_i};

	// One synchroniser for all three pins keeps their delays equal
	rspd_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.d_i(pin_raw),
		.q_o(pin_sync)
	);

	assign osc_s = pin_sync[0];
	assign sclr_n_s = pin_sync[1];
	assign bus_req_s = pin_sync[2];

	// Falling oscillator edge seen in the system domain
	assign osc_fall = osc_prev_q && !osc_s;

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			osc_prev_q <= 1'b0;
		else
			osc_prev_q <= osc_s;
	end

	// Clear input sampled only at oscillator falls
	always @* begin
		sclr_smp_d = sclr_smp_q;
		if (osc_fall)
			sclr_smp_d = sclr_n_s;
	end

	// Second low sample in a row means two falls since assertion
	assign warm_enter = osc_fall && !sclr_n_s && !sclr_smp_q;
	assign sclr_fall = osc_fall && !sclr_n_s && sclr_smp_q;
	assign recognise = osc_fall && sclr_n_s && !sclr_smp_q &&
		pins_reset_q;

	// Beat skipped only when clock is high at recognition
	assign skip_beat = recognise && clkout_q;

	rspd_divider u_divider (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.osc_fall_i(osc_fall),
		.enable_i(act_en_q),
		.sel_i(act_sel_q),
		.restart_i(apply),
		.toggle_o(div_toggle)
	);

	assign toggle_eff = div_toggle && !skip_beat;
	assign clock_fall = toggle_eff && clkout_q;

	// Clock held in a flop; it moves only on oscillator falls
	always @* begin
		clkout_d = clkout_q;
		if (toggle_eff)
			clkout_d = !clkout_q;
	end

	// Registered so the pulse is clean and one cycle long
	always @* begin
		realign_d = sclr_fall;
	end

	// Terminal counts; the release counter only sees clock falls
	assign rel_last = (rel_cnt_q + 2'h1 == `RSPD_REL_FALLS);
	assign start_last =
		(start_cnt_q + 4'h1 == `RSPD_BUS_START_HALF);

	// Reset sequencing: entry, release and bus start
	always @* begin
		pins_reset_d = pins_reset_q;
		sclr_out_d = sclr_out_q;
		recog_d = recog_q;
		rel_cnt_d = rel_cnt_q;
		start_cnt_d = start_cnt_q;
		bus_active_d = bus_active_q;
		if (warm_enter) begin
			pins_reset_d = 1'b1;
			sclr_out_d = 1'b1;
			recog_d = 1'b0;
			rel_cnt_d = 2'h0;
			start_cnt_d = 4'h0;
			bus_active_d = 1'b0;
		end else begin
			if (recognise) begin
				recog_d = 1'b1;
				rel_cnt_d = 2'h0;
				start_cnt_d = 4'h0;
			end
			if (recog_q && sclr_out_q && clock_fall) begin
				if (rel_last) begin
					sclr_out_d = 1'b0;
					pins_reset_d = 1'b0;
				end
				rel_cnt_d = rel_cnt_q + 2'h1;
			end
			// Half periods counted so the count lands mid period
			if (recog_q && !bus_active_q && toggle_eff) begin
				if (start_last) begin
					bus_active_d = 1'b1;
					recog_d = 1'b0;
				end
				start_cnt_d = start_cnt_q + 4'h1;
			end
		end
	end

	// Clock and reset sequencing state
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclr_smp_q <= 1'b0;
			clkout_q <= 1'b0;
			realign_q <= 1'b0;
			pins_reset_q <= 1'b1;
			sclr_out_q <= 1'b1;
			recog_q <= 1'b0;
			rel_cnt_q <= 2'h0;
			start_cnt_q <= 4'h0;
			bus_active_q <= 1'b0;
		end else begin
			sclr_smp_q <= sclr_smp_d;
			clkout_q <= clkout_d;
			realign_q <= realign_d;
			pins_reset_q <= pins_reset_d;
			sclr_out_q <= sclr_out_d;
			recog_q <= recog_d;
			rel_cnt_q <= rel_cnt_d;
			start_cnt_q <= start_cnt_d;
			bus_active_q <= bus_active_d;
		end
	end

	// Register port; never stalls, but writes to the power-save register are dropped while pins are in reset
	assign psc_hit = (reg_addr_i == `RSPD_PSC_ADDR);
	assign stat_hit = (reg_addr_i == `RSPD_STAT_ADDR);
	assign psc_write = reg_we_i && psc_hit;

	// These two inputs end power save; software can also end it by writing the enable bit to 0
	assign exit_req = (unmasked_irq_i || nmi_i) &&
		psc_q[`RSPD_PSC_EN_BIT];

	// Software change waiting, or being written right now
	assign sw_pend = pend_q || psc_write;

	// Exit noted once, then spent at the next third state
	assign exit_set = exit_req && !exit_pend_q;
	assign exit_taken = exit_pend_q && third_bus_state_i;

	// A new setting takes effect only at a third-state fall
	assign apply = third_bus_state_i &&
		(sw_pend || exit_pend_q);

	always @* begin
		psc_d = psc_q;
		if (pins_reset_q)
			psc_d = `RSPD_PSC_RESET;
		else if (psc_write)
			psc_d = reg_wdata_i & `RSPD_PSC_WMASK;
		else if (exit_taken)
			psc_d[`RSPD_PSC_EN_BIT] = 1'b0;
		// Return from interrupt has no path back to the enable bit.
	end

	// Software change held until a third state can apply it
	always @* begin
		pend_d = pend_q;
		if (pins_reset_q)
			pend_d = 1'b0;
		else if (psc_write)
			pend_d = !third_bus_state_i;
		else if (third_bus_state_i)
			pend_d = 1'b0;
	end

	// Set wins over the clear at the same third state
	always @* begin
		exit_pend_d = exit_pend_q;
		if (pins_reset_q)
			exit_pend_d = 1'b0;
		else if (exit_set)
			exit_pend_d = 1'b1;
		else if (exit_taken)
			exit_pend_d = 1'b0;
	end

	// Setting in use moves only at a third state or while pins are in reset, so no clock glitch
	always @* begin
		act_en_d = act_en_q;
		act_sel_d = act_sel_q;
		if (pins_reset_q) begin
			act_en_d = 1'b0;
			act_sel_d = `RSPD_DIV_SEL_1;
		end else if (apply) begin
			act_en_d = psc_d[`RSPD_PSC_EN_BIT];
			act_sel_d = psc_d[`RSPD_PSC_SEL_HI:`RSPD_PSC_SEL_LO];
		end
	end

	// Status shows the setting in use, not the one last written
	always @* begin
		stat_word = {`RSPD_DATA_W{1'b0}};
		stat_word[`RSPD_STAT_ACT_EN] = act_en_q;
		stat_word[`RSPD_STAT_SCLR_OUT] = sclr_out_q;
		stat_word[`RSPD_STAT_PIN_RST] = pins_reset_q;
		stat_word[`RSPD_STAT_BUS_ACT] = bus_active_q;
		stat_word[`RSPD_STAT_SEL_HI:`RSPD_STAT_SEL_LO] = act_sel_q;
		stat_word[`RSPD_STAT_PEND] = pend_q;
		stat_word[`RSPD_STAT_EXIT] = exit_pend_q;
	end

	// Read data valid only in the cycle after the strobe
	always @* begin
		rdata_d = {`RSPD_DATA_W{1'b0}};
		if (reg_re_i) begin
			if (psc_hit)
				rdata_d = psc_q;
			else if (stat_hit)
				rdata_d = stat_word;
			else
				rdata_d = {`RSPD_DATA_W{1'b0}};
		end
	end

	// Register bank and the setting in use
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			psc_q <= `RSPD_PSC_RESET;
			pend_q <= 1'b0;
			exit_pend_q <= 1'b0;
			act_en_q <= 1'b0;
			act_sel_q <= `RSPD_DIV_SEL_1;
			rdata_q <= {`RSPD_DATA_W{1'b0}};
		end else begin
			psc_q <= psc_d;
			pend_q <= pend_d;
			exit_pend_q <= exit_pend_d;
			act_en_q <= act_en_d;
			act_sel_q <= act_sel_d;
			rdata_q <= rdata_d;
		end
	end

	// Grant follows the synchronised request, two cycles late, while out of bus activity
	assign bus_grant_ack_o = !bus_active_q && bus_req_s;
	assign prefetch_enable_o = bus_active_q && !bus_grant_ack_o;

	assign reg_rdata_o = rdata_q;
	assign clkout_o = clkout_q;
	assign system_clear_output_o = sclr_out_q;
	assign pins_reset_o = pins_reset_q;
	assign phase_realign_pulse_o = realign_q;
	assign bus_active_o = bus_active_q;
	assign power_save_active_o = act_en_q;
endmodule // rspd_top

// ===== verification/rspd_monitor.sv
// Port checker for rspd_top.
// Assumes one system clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module rspd_monitor (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire bus_request_i,
	input wire third_bus_state_i,
	input wire reg_re_i,
	input wire [7:0] reg_addr_i,
	input wire [15:0] reg_rdata_o,
	input wire clkout_o,
	input wire system_clear_output_o,
	input wire pins_reset_o,
	input wire phase_realign_pulse_o,
	input wire bus_grant_ack_o,
	input wire bus_active_o,
	input wire prefetch_enable_o,
	input wire power_save_active_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	sequence clk_fell_s;
		$past(clkout_o) && !clkout_o;
	endsequence
	sequence clk_moved_s;
		clkout_o != $past(clkout_o);
	endsequence
	realign_pulse_a: assert property (
		phase_realign_pulse_o |=> !phase_realign_pulse_o)
		else $error("realign pulse longer than one cycle");
	clear_release_a: assert property (
		$fell(system_clear_output_o) |-> clk_fell_s and $fell(pins_reset_o))
		else $error("clear output released off a clock fall");
	bus_start_a: assert property (
		$rose(bus_active_o) |-> clk_moved_s ##0 !system_clear_output_o)
		else $error("bus start not on a clock toggle");
	grant_idle_a: assert property (
		bus_active_o |-> !bus_grant_ack_o)
		else $error("grant while bus active");
	no_prefetch_a: assert property (
		bus_grant_ack_o |-> !prefetch_enable_o)
		else $error("prefetch while granted");
	grant_req_a: assert property (
		!bus_active_o && $past(bus_request_i, 2) && $past(bus_request_i, 3)
		|-> bus_grant_ack_o)
		else $error("request in reset not granted");
	rate_change_a: assert property (
		$changed(power_save_active_o) |-> $past(third_bus_state_i) ||
		pins_reset_o || $past(pins_reset_o) || $past(pins_reset_o, 2))
		else $error("rate changed away from third state");
	rdata_idle_a: assert property (
		!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside answer cycle");
	reserved_read_a: assert property (
		$past(reg_re_i) && $past(reg_addr_i) == 8'h00 |->
		(reg_rdata_o & 16'h7FFC) == 16'h0000)
		else $error("reserved bits read nonzero");
endmodule // rspd_monitor

bind rspd_top rspd_monitor i_mon (.clk_sys_i(clk_sys_i),
	.resetn_i(resetn_i), .bus_request_i(bus_request_i),
	.third_bus_state_i(third_bus_state_i), .reg_re_i(reg_re_i),
	.reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
	.clkout_o(clkout_o), .system_clear_output_o(system_clear_output_o),
	.pins_reset_o(pins_reset_o),
	.phase_realign_pulse_o(phase_realign_pulse_o),
	.bus_grant_ack_o(bus_grant_ack_o), .bus_active_o(bus_active_o),
	.prefetch_enable_o(prefetch_enable_o),
	.power_save_active_o(power_save_active_o));

// ===== verification/rspd_env_src.sv
// Clear pin source and free-running oscillator for rspd_top.
// Assumes warm_i is a one-cycle request from the bench.
`timescale 1ns/1ps
module rspd_env_src (
	input wire clk_sys_i,
	input wire warm_i,
	output reg osc_o,
	output reg clear_n_o
);
	integer low_cnt;
	// Offset keeps oscillator edges off the sampling edge
	initial begin
		osc_o = 1'b1;
		clear_n_o = 1'b0;
		low_cnt = 60;
		#1.3;
		forever #12.5 osc_o = ~osc_o;
	end
	// Sixty cycles is six undivided clock periods
	always @(posedge clk_sys_i) begin
		if (warm_i)
			low_cnt <= 60;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
		clear_n_o <= (low_cnt == 0) && !warm_i;
	end
endmodule // rspd_env_src

// ===== verification/reset_sync_and_power_save_divider_tb_top.sv
// Self-checking bench for rspd_top.
// Assumes rspd_env_src drives the oscillator and clear pins.
`timescale 1ns/1ps
module reset_sync_and_power_save_divider_tb_top;
	reg clk_sys_i, resetn_i, bus_request_i, third_bus_state_i;
	reg unmasked_irq_i, nmi_i, reg_we_i, reg_re_i, warm;
	reg [7:0] reg_addr_i;
	reg [15:0] reg_wdata_i, d, g;
	reg [31:0] rnd;
	wire osc, clr_n, clkout_o, sclr, pins, realign, grant, bus_act, pref, psa;
	wire [15:0] reg_rdata_o;
	integer error_cnt, checked, s, k, realign_cnt;
	rspd_env_src i_src (.clk_sys_i(clk_sys_i), .warm_i(warm), .osc_o(osc),
		.clear_n_o(clr_n));
	rspd_top i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.oscillator_input_i(osc), .system_clear_input_n_i(clr_n),
		.bus_request_i(bus_request_i), .third_bus_state_i(third_bus_state_i),
		.unmasked_irq_i(unmasked_irq_i), .nmi_i(nmi_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.clkout_o(clkout_o), .system_clear_output_o(sclr),
		.pins_reset_o(pins), .phase_realign_pulse_o(realign),
		.bus_grant_ack_o(grant), .bus_active_o(bus_act),
		.prefetch_enable_o(pref), .power_save_active_o(psa));
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
		if (realign === 1'b1)
			realign_cnt <= realign_cnt + 1;
	function [31:0] lfsr_next(input [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Toggle gap in system cycles: five per oscillator fall
	function [15:0] gap_of(input integer sel, input en);
		gap_of = (en && sel != 0) ? 16'h0005 << (sel + 1) : 16'h0005;
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [15:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_we_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask
	task rd(input [7:0] a, output [15:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		@(negedge clk_sys_i);
		v = reg_rdata_o;
	endtask
	task tick;
		@(posedge clk_sys_i);
		third_bus_state_i <= 1'b1;
		@(posedge clk_sys_i);
		third_bus_state_i <= 1'b0;
	endtask
	// First gap may be partial, so the second is kept
	task meas(output [15:0] c);
		reg v;
		repeat (2) begin
			c = 0;
			v = clkout_o;
			while (clkout_o === v && c < 16'h0200) begin
				@(negedge clk_sys_i);
				c = c + 1;
			end
		end
	endtask
	task conclude;
		$display("counts: checked=%0d errors=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial begin
		clk_sys_i = 1'b0;
		resetn_i = 1'b0;
		{bus_request_i, third_bus_state_i, unmasked_irq_i, nmi_i} = 4'h0;
		{reg_we_i, reg_re_i, warm} = 3'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 16'h0000;
		error_cnt = 0;
		checked = 0;
		realign_cnt = 0;
		rnd = 32'h6FD158ED;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		for (k = 0; k < 1000 && bus_act !== 1'b1; k = k + 1)
			@(posedge clk_sys_i);
		check({15'h0000, bus_act}, 16'h0001);
		check({15'h0000, sclr}, 16'h0000);
		rd(8'h00, d);
		check(d, 16'h0000);
		rd(8'h3C, d);
		check(d, 16'h0000);
		meas(g);
		check(g, 16'h0005);
		$display("test reset done");
		// Every divisor, then random ones; the last pass disables
		for (s = 0; s < 8; s = s + 1) begin
			rnd = lfsr_next(rnd);
			g = {s != 7, 13'h0000, (s < 4) ? s[1:0] : rnd[1:0]};
			wr(8'h00, g);
			rd(8'h00, d);
			check(d, g);
			tick;
			meas(d);
			check(d, gap_of(g[1:0], g[15]));
		end
		$display("test divider done");
		for (s = 0; s < 2; s = s + 1) begin
			wr(8'h00, 16'h8003);
			tick;
			@(negedge clk_sys_i);
			check({15'h0000, psa}, 16'h0001);
			@(posedge clk_sys_i);
			unmasked_irq_i <= (s == 0);
			nmi_i <= (s == 1);
			tick;
			unmasked_irq_i <= 1'b0;
			nmi_i <= 1'b0;
			tick;
			rd(8'h00, d);
			check(d, 16'h0003);
			check({15'h0000, psa}, 16'h0000);
		end
		$display("test interrupt exit done");
		@(posedge clk_sys_i);
		bus_request_i <= 1'b1;
		warm <= 1'b1;
		@(posedge clk_sys_i);
		warm <= 1'b0;
		for (k = 0; k < 200 && pins !== 1'b1; k = k + 1)
			@(posedge clk_sys_i);
		repeat (4) @(negedge clk_sys_i);
		check({15'h0000, pins}, 16'h0001);
		check({14'h0000, grant, pref}, 16'h0002);
		@(posedge clk_sys_i);
		bus_request_i <= 1'b0;
		for (k = 0; k < 1000 && bus_act !== 1'b1; k = k + 1)
			@(posedge clk_sys_i);
		check({15'h0000, bus_act}, 16'h0001);
		check(realign_cnt[15:0], 16'h0001);
		$display("test warm reset done");
		conclude;
	end
endmodule // reset_sync_and_power_save_divider_tb_top
